// [design/plsr_consts.svh]
/*
  Offsets, field positions and reset values for the port link status bank.
  Assumes inclusion by bare name from the package and the design.
*/
`ifndef PLSR_CONSTS_SVH
`define PLSR_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index
`define PLSR_OFF_P1_STATE    7'h1e
`define PLSR_OFF_P1_RESULT   7'h1f
`define PLSR_OFF_P2_STATE    7'h2e
`define PLSR_OFF_P2_RESULT   7'h2f
`define PLSR_OFF_P3_SLOT     7'h3e
`define PLSR_OFF_OAM_CFG     7'h40
`define PLSR_OFF_IRQ_STATUS  7'h50
`define PLSR_OFF_IRQ_MASK    7'h54

`define PLSR_BIT_XOVER_SEL   7
`define PLSR_BIT_RSVD6       6
`define PLSR_RST_XOVER_SEL   1'b1
`define PLSR_RST_OAM_COUNT   3'h0
`define PLSR_RST_PHY_BASE    5'h01
`define PLSR_MAX_OAM_COUNT   3'h4
`define PLSR_MIN_PHY_BASE    5'h01
`define PLSR_MAX_PHY_BASE    5'h1d
`define PLSR_STRAP_CENTER    2'h1
`define PLSR_IRQ_BITS        4

`endif

// [design/plsr_pkg.sv]
/*
  Types for the port link status bank.
  Assumes the constants header sits beside it.
*/
`include "plsr_consts.svh"

package plsr_pkg;

  // Live state of one PHY port, driven by the PHY logic
  typedef struct packed {
    logic       crossover_state;
    logic       negotiation_complete;
    logic       link_good;
    logic       partner_pause;
    logic [3:0] partner_abilities;
    logic       polarity_reversed;
    logic       tx_flow_active;
    logic       rx_flow_active;
    logic       speed_100;
    logic       full_duplex;
    logic       far_end_fault;
  } plsr_port_s;

  // Settings handed to the converter and PHY logic
  typedef struct packed {
    logic [2:0] oam_count;
    logic [4:0] phy_base;
    logic [4:0] phy_port2;
    logic       xover_sel_p1;
    logic       xover_sel_p2;
  } plsr_cfg_s;

endpackage

// [design/plsr_regs.sv]
/*
  APB register bank: per-port link status, crossover algorithm select,
  converter OAM count and PHY base address, plus link-change interrupts.
  Assumes port status inputs are synchronous to pclk and APB comes from
  a well-behaved master.
*/
`timescale 1ns/1ns
`include "plsr_consts.svh"

module plsr_regs (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [8:0]           paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Port status
  input  wire plsr_pkg::plsr_port_s port1_status,
  input  wire plsr_pkg::plsr_port_s port2_status,
  // Converter role straps
  input  wire logic                 converter_role_strap_a,
  input  wire logic                 converter_role_strap_b,
  // Configuration out
  output plsr_pkg::plsr_cfg_s       cfg,
  output logic                      center_start,
  output logic                      irq
);
  import plsr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic [7:0] state_byte(input plsr_port_s p);
    state_byte = {p.crossover_state, p.negotiation_complete, p.link_good,
                  p.partner_pause,
                  p.partner_abilities};
  endfunction

  function automatic logic [7:0] result_byte(input plsr_port_s p, input logic sel,
                                             input logic fiber);
    result_byte = {sel, 1'b0,
                   p.polarity_reversed,
                   p.tx_flow_active,
                   p.rx_flow_active,
                   p.speed_100,
                   p.full_duplex,
                   p.far_end_fault & fiber};
  endfunction

  function automatic logic [3:0] link_bits(input plsr_port_s a, input plsr_port_s b);
    link_bits = {b.far_end_fault, b.link_good, a.far_end_fault, a.link_good};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers and access strobes

  logic             xsel1_q;
  logic             xsel2_q;
  logic [2:0]       oam_count_q;
  logic [4:0]       phy_base_q;
  logic [`PLSR_IRQ_BITS-1:0] irq_stat_q;
  logic [`PLSR_IRQ_BITS-1:0] irq_mask_q;
  logic [`PLSR_IRQ_BITS-1:0] link_prev_q;
  logic [`PLSR_IRQ_BITS-1:0] link_now;
  logic [`PLSR_IRQ_BITS-1:0] link_evt;
  logic             wr_en;
  logic             rd_en;
  logic             mapped;
  logic [31:0]      rd_d;
  logic             center_mode;
  logic [6:0]       reg_idx;

  // Word index; each register holds one aligned word
  assign reg_idx     = paddr[8:2];
  // Access phase only; one cycle of wait via pready register
  assign wr_en       = psel & penable & pwrite & pready;
  assign rd_en       = psel & penable & ~pwrite & pready;
  assign link_now    = link_bits(port1_status, port2_status);
  assign link_evt    = link_now ^ link_prev_q;
  assign center_mode = {converter_role_strap_a, converter_role_strap_b} == `PLSR_STRAP_CENTER;

  // Address map, reserved slot maps and reads zero
  always_comb begin
    mapped = 1'b1;
    rd_d   = 32'h0;
    case (reg_idx)
      `PLSR_OFF_P1_STATE:   rd_d[7:0] = state_byte(port1_status);
      `PLSR_OFF_P1_RESULT:  rd_d[7:0] = result_byte(port1_status, xsel1_q, 1'b1);
      `PLSR_OFF_P2_STATE:   rd_d[7:0] = state_byte(port2_status);
      `PLSR_OFF_P2_RESULT:  rd_d[7:0] = result_byte(port2_status, xsel2_q, 1'b0);
      `PLSR_OFF_P3_SLOT:    rd_d      = 32'h0;
      `PLSR_OFF_OAM_CFG:    rd_d[7:0] = {oam_count_q, phy_base_q};
      `PLSR_OFF_IRQ_STATUS: rd_d[`PLSR_IRQ_BITS-1:0] = irq_stat_q;
      `PLSR_OFF_IRQ_MASK:   rd_d[`PLSR_IRQ_BITS-1:0] = irq_mask_q;
      default:              mapped = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB handshake: answer one cycle after penable rises

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  // Read data and error are registered; reads change no state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata  <= pwrite ? 32'h0 : rd_d;
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writable settings; only bit 7 of result registers is writable

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xsel1_q <= `PLSR_RST_XOVER_SEL;
      xsel2_q <= `PLSR_RST_XOVER_SEL;
    end else if (wr_en & pstrb[0]) begin
      if (reg_idx == `PLSR_OFF_P1_RESULT) begin
        xsel1_q <= pwdata[`PLSR_BIT_XOVER_SEL];
      end
      if (reg_idx == `PLSR_OFF_P2_RESULT) begin
        xsel2_q <= pwdata[`PLSR_BIT_XOVER_SEL];
      end
    end
  end

  // Invalid codes are dropped field by field so a bad write cannot misconfigure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oam_count_q <= `PLSR_RST_OAM_COUNT;
      phy_base_q  <= `PLSR_RST_PHY_BASE;
    end else if (wr_en & pstrb[0] & (reg_idx == `PLSR_OFF_OAM_CFG)) begin
      if (pwdata[7:5] <= `PLSR_MAX_OAM_COUNT) begin
        oam_count_q <= pwdata[7:5];
      end
      if ((pwdata[4:0] >= `PLSR_MIN_PHY_BASE) && (pwdata[4:0] <= `PLSR_MAX_PHY_BASE)) begin
        phy_base_q <= pwdata[4:0];
      end
    end
  end

  // Start pulse on address write in center mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      center_start <= 1'b0;
    end else begin
      center_start <= wr_en & pstrb[0] & (reg_idx == `PLSR_OFF_OAM_CFG)
                      & center_mode
                      & (pwdata[4:0] >= `PLSR_MIN_PHY_BASE)
                      & (pwdata[4:0] <= `PLSR_MAX_PHY_BASE);
    end
  end

  // Configuration outputs registered one cycle behind the settings;
  // phy_port2 is phy_base plus one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '0;
    end else begin
      cfg.oam_count    <= oam_count_q;
      cfg.phy_base     <= phy_base_q;
      cfg.phy_port2    <= phy_base_q + 5'h01;
      cfg.xover_sel_p1 <= xsel1_q;
      cfg.xover_sel_p2 <= xsel2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: link or fault change sets sticky bit; set beats clear

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_prev_q <= '0;
    end else begin
      link_prev_q <= link_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else if (wr_en & pstrb[0] & (reg_idx == `PLSR_OFF_IRQ_STATUS)) begin
      irq_stat_q <= (irq_stat_q & ~pwdata[`PLSR_IRQ_BITS-1:0]) | link_evt;
    end else begin
      irq_stat_q <= irq_stat_q | link_evt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_en & pstrb[0] & (reg_idx == `PLSR_OFF_IRQ_MASK)) begin
      irq_mask_q <= pwdata[`PLSR_IRQ_BITS-1:0];
    end
  end

  // Registered, so irq trails status by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule

// [verification/plsr_link_partner.sv]
/*
  Link partner stand-in: drives the live status of both PHY ports.
  Assumes the bench names the wanted state; zero while in reset.
*/
`timescale 1ns/1ns
module plsr_link_partner (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Wanted and live status
  input  wire plsr_pkg::plsr_port_s want1,
  input  wire plsr_pkg::plsr_port_s want2,
  output plsr_pkg::plsr_port_s      port1_status,
  output plsr_pkg::plsr_port_s      port2_status
);
  import plsr_pkg::*;
  // Changes land on an edge only, as a synchronous PHY would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port1_status <= '0;
      port2_status <= '0;
    end else begin
      port1_status <= want1;
      port2_status <= want2;
    end
  end
endmodule

// [verification/plsr_regs_sva.sv]
/*
  Checker for the link status bank, bound to its ports.
  Assumes one pclk domain and a master that holds until pready.
*/
`timescale 1ns/1ns
module plsr_regs_sva (
  // Clock and reset
  input wire logic                 pclk,
  input wire logic                 presetn,
  // APB
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [8:0]           paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Port and settings
  input wire plsr_pkg::plsr_port_s port1_status,
  input wire plsr_pkg::plsr_cfg_s  cfg,
  input wire logic                 center_start
);
  import plsr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read answer in this cycle
  wire rd_ans = pready && !pwrite;
  sequence s_acc_open; $rose(penable); endsequence
  sequence s_one_wait; !pready ##1 pready; endsequence
  ////////////////////////////////////////////////////////////
  AST_ONE_WAIT: assert property (s_acc_open |-> s_one_wait)
    else $error("pready not after one wait state");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  AST_P2_ADDR: assert property (
    $past(presetn) |-> cfg.phy_port2 == cfg.phy_base + 5'h01)
    else $error("port 2 address not base plus one");
  AST_BASE_OK: assert property (
    $past(presetn) |-> cfg.phy_base inside {[5'h01:5'h1d]})
    else $error("invalid phy base stored");
  AST_COUNT_OK: assert property (cfg.oam_count <= 3'h4)
    else $error("invalid frame count stored");
  AST_START: assert property (
    center_start |-> $past(pready && pwrite && paddr == 9'h100))
    else $error("start without address write");
  AST_RSVD6: assert property (
    rd_ans && (paddr == 9'h07c || paddr == 9'h0bc) |-> !prdata[6])
    else $error("reserved bit reads one");
  AST_FEF_P2: assert property (rd_ans && paddr == 9'h0bc |-> !prdata[0])
    else $error("port 2 fault bit set");
  AST_P1_LIVE: assert property (
    rd_ans && paddr == 9'h078 && $stable(port1_status) |-> prdata[7:0] == port1_status[13:6])
    else $error("port 1 state read wrong");
  AST_SLOT: assert property (
    pready && paddr == 9'h0f8 |-> !pslverr && (pwrite || prdata == 32'h0))
    else $error("reserved slot misbehaves");
endmodule
bind plsr_regs plsr_regs_sva u_sva (.pclk, .presetn, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .port1_status, .cfg, .center_start);

// [verification/testbench.sv]
/*
  Bench for the link status bank: APB master tasks and hand-made scenarios.
  Assumes partner and checker compile first; pclk runs at 100 MHz.
*/
`timescale 1ns/1ns
module testbench;
  import plsr_pkg::*;
  // Pins, partner wishes and tallies
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [8:0]  paddr = 9'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr, center_start, irq;
  logic        converter_role_strap_a = 1'b1, converter_role_strap_b = 1'b1;
  plsr_port_s  want1 = '0, want2 = '0, port1_status, port2_status;
  plsr_cfg_s   cfg;
  int          error_cnt = 0, checks_done = 0, cyc = 0, n_start = 0;
  localparam logic [13:0] PATS [3] = '{14'h3fff, 14'h1555, 14'h2aaa};
  localparam logic [7:0]  WD [9] = '{8'h41, 8'h9d, 8'hbe, 8'h60, 8'h1f, 8'h22, 8'he5, 8'hc5, 8'h03};
  localparam logic [7:0]  EX [9] = '{8'h41, 8'h9d, 8'h9d, 8'h7d, 8'h1d, 8'h22, 8'h25, 8'h25, 8'h03};
  localparam logic [8:0]  ST = 9'h0e3;
  plsr_regs dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .port1_status, .port2_status, .converter_role_strap_a,
    .converter_role_strap_b, .cfg, .center_start, .irq);
  plsr_link_partner partner (.pclk, .presetn, .want1, .want2, .port1_status, .port2_status);
  always #5 pclk = ~pclk;
  // Watchdog and start tally; the tally lets a lost or extra pulse show
  always @(posedge pclk) begin
    cyc++;
    if (center_start === 1'b1) n_start++;
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Entered just after an edge; answer taken at the edge that shows pready
  // No wait count assumed; only the watchdog ends a hung access
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat);
  endtask
  task automatic t_reset();
    rd(9'h078, 32'h00, "p1_state");
    rd(9'h07c, 32'h80, "p1_result");
    rd(9'h0b8, 32'h00, "p2_state");
    rd(9'h0bc, 32'h80, "p2_result");
    rd(9'h100, 32'h01, "oam_cfg");
    rd(9'h0f8, 32'h00, "p3_slot");
    chk("p3_err", 32'h0, rerr);
    rd(9'h180, 32'h0, "unmapped");
    chk("unmapped_err", 32'h1, rerr);
  endtask
  // Each pattern reads p1 state twice over a write attempt: the write must not disturb
  task automatic t_status();
    logic [13:0] p;
    for (int i = 0; i < 3; i++) begin
      p = PATS[i];
      want1 <= p;
      want2 <= ~p;
      repeat (3) @(posedge pclk);
      rd(9'h078, {24'h0, p[13:6]}, "p1_state");
      rd(9'h07c, {24'h0, 2'b10, p[5:0]}, "p1_result");
      rd(9'h0b8, {24'h0, ~p[13:6]}, "p2_state");
      rd(9'h0bc, {24'h0, 2'b10, ~p[5:1], 1'b0}, "p2_result");
      apb(1'b1, 9'h078, 32'hff);
      rd(9'h078, {24'h0, p[13:6]}, "p1_state_ro");
    end
  endtask
  task automatic t_xover();
    want1 <= '0;
    want2 <= '0;
    apb(1'b1, 9'h07c, 32'h40);
    rd(9'h07c, 32'h00, "p1_xsel_low");
    rd(9'h0bc, 32'h80, "p2_xsel_kept");
    chk("cfg_xsel", 32'h1, {30'h0, cfg.xover_sel_p1, cfg.xover_sel_p2});
    apb(1'b1, 9'h07c, 32'h80);
    rd(9'h07c, 32'h80, "p1_xsel_back");
  endtask
  // Last entry leaves center mode, so a valid write must not start
  task automatic t_oam();
    int s;
    for (int i = 0; i < 9; i++) begin
      converter_role_strap_a <= (i == 8);
      converter_role_strap_b <= 1'b1;
      s = n_start;
      apb(1'b1, 9'h100, {24'h0, WD[i]});
      @(posedge pclk);
      chk("starts", ST[i], n_start - s);
      chk("cfg", {EX[i][4:0] + 5'h01, EX[i]}, {cfg.phy_port2, cfg.oam_count, cfg.phy_base});
      rd(9'h100, EX[i], "oam_cfg");
    end
  endtask
  task automatic t_irq();
    apb(1'b1, 9'h140, 32'hf);
    apb(1'b1, 9'h150, 32'h1);
    want1 <= 14'h0800;
    repeat (4) @(posedge pclk);
    chk("irq_up", 32'h1, irq);
    rd(9'h140, 32'h1, "irq_status");
    apb(1'b1, 9'h140, 32'h1);
    @(posedge pclk);
    chk("irq_cleared", 32'h0, irq);
    apb(1'b1, 9'h150, 32'h0);
    want1 <= 14'h0801;
    want2 <= 14'h0800;
    repeat (4) @(posedge pclk);
    chk("irq_masked", 32'h0, irq);
    rd(9'h140, 32'h6, "irq_status2");
    apb(1'b1, 9'h150, 32'h2);
    @(posedge pclk);
    chk("irq_unmasked", 32'h1, irq);
  endtask
  // Reset for six edges, then the scenarios in turn
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_xover();
    t_oam();
    t_irq();
    print_verdict();
  end
endmodule
